/* File: core/sdcw_pkg.sv */
// Purpose: shared constants and carriers for the driver-control decoder
// Assumes: 20-bit serial words, msb first
// Notes:   no registers have bus offsets; words are routed by their top bits
package sdcw_pkg;
  localparam int WORD_W       = 20;
  localparam int CNT_W        = 5;
  localparam int SEL_BIT      = 19;
  localparam int RSV_BIT      = 18;
  localparam int PHU_POL_BIT  = 17;
  localparam int PHU_MAG_HI   = 16;
  localparam int PHU_MAG_LO   = 9;
  localparam int PHV_POL_BIT  = 8;
  localparam int PHV_MAG_HI   = 7;
  localparam int STEP_INTERPOLATION_ENABLE_BIT   = 9;
  localparam int DUAL_EDGE_STEP_ENABLE_BIT    = 8;
  localparam int RB_HI        = 19;
  localparam int RB_LO        = 10;
  localparam int CFG_SD_BIT   = 7;
  localparam int CFG_RS_HI    = 5;
  localparam int CFG_RS_LO    = 4;
  localparam logic [2:0] CFG_SEL = 3'h7;
  localparam logic [1:0] RDS_MICROSTEP_POSITION = 2'h0;
  localparam logic [1:0] RDS_STALL = 2'h1;
  localparam logic [1:0] RDS_SCALE = 2'h2;
  localparam logic [3:0] MICROSTEP_RESOLUTION_MAX  = 4'h8;
  localparam logic [3:0] MICROSTEP_RESOLUTION_INT  = 4'h4;
  localparam logic [3:0] INT_MULT  = 4'hf;
  localparam logic [9:0] MICROSTEP_POSITION_RST = 10'h000;

  typedef struct packed {
    logic       pol;
    logic [7:0] mag;
  } sdcw_phase_t;

  typedef struct packed {
    logic        sck_m;
    logic        sck_s;
    logic        sck_d;
    logic        csn_m;
    logic        csn_s;
    logic        csn_d;
    logic        sdi_m;
    logic        sdi_s;
    logic        step_m;
    logic        step_s;
    logic        step_d;
    logic        dir_m;
    logic        dir_s;
    logic [19:0] shin;
    logic [19:0] shout;
    logic [4:0]  bits;
    logic        sdo;
    logic        sd_off;
    logic [1:0]  readback_select;
    sdcw_phase_t ph_u;
    sdcw_phase_t ph_v;
    logic        ph_w_pol;
    logic [8:0]  ph_w_mag;
    logic        step_interpolation_enable;
    logic        dual_edge_step_enable;
    logic [3:0]  microstep_resolution;
    logic [9:0]  microstep_position;
    logic [3:0]  sub_left;
    logic        sub_dir;
    logic        wr_pulse;
  } sdcw_state_t;
endpackage : sdcw_pkg

/* File: core/sdcw_core.sv */
// Purpose: serial driver-control word decode and read-back word builder
// Assumes: serial clock at most half of MCLK; mode 0 shift (sample rise)
// Notes:   step/direction and serial pins are synchronised to MCLK
`timescale 1ns/1ps
`default_nettype none
module sdcw_core (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // serial port
  input  wire logic        SCK,
  input  wire logic        CS_N,
  input  wire logic        SDI,
  output logic             SDO,
  // step and direction pins
  input  wire logic        STEP,
  input  wire logic        DIR,
  // status from the analogue side
  input  wire logic [9:0]  STALL_LOAD,
  input  wire logic [4:0]  CURRENT_SCALE,
  input  wire logic [7:0]  STATUS_FLAGS,
  // decoded driver outputs
  output logic             STEPDIR_DISABLE,
  output logic             PHASE_U_POL,
  output logic [7:0]       PHASE_U_MAG,
  output logic             PHASE_V_POL,
  output logic [7:0]       PHASE_V_MAG,
  output logic             PHASE_W_POL,
  output logic [8:0]       PHASE_W_MAG,
  output logic             INTERP_EN,
  output logic             DUAL_EDGE_EN,
  output logic [3:0]       MICROSTEP_RES,
  output logic [9:0]       MICROSTEP_POS,
  output logic             WORD_STROBE
);
  sdcw_pkg::sdcw_state_t s_r;
  sdcw_pkg::sdcw_state_t s_nxt;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_end;
    logic        cs_start;
    logic        step_ev;
    logic [9:0]  stepw;
    logic [9:0]  mhi;
    logic [19:0] w;
    logic signed [9:0] su;
    logic signed [9:0] sv;
    logic signed [9:0] sw;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    cs_end   = 1'b0;
    cs_start = 1'b0;
    step_ev  = 1'b0;
    stepw    = 10'h000;
    mhi      = 10'h000;
    w        = 20'h00000;
    su       = 10'sh000;
    sv       = 10'sh000;
    sw       = 10'sh000;
    s_nxt    = s_r;
    s_nxt.sck_m  = SCK;
    s_nxt.sck_s  = s_r.sck_m;
    s_nxt.sck_d  = s_r.sck_s;
    s_nxt.csn_m  = CS_N;
    s_nxt.csn_s  = s_r.csn_m;
    s_nxt.csn_d  = s_r.csn_s;
    s_nxt.sdi_m  = SDI;
    s_nxt.sdi_s  = s_r.sdi_m;
    s_nxt.step_m = STEP;
    s_nxt.step_s = s_r.step_m;
    s_nxt.step_d = s_r.step_s;
    s_nxt.dir_m  = DIR;
    s_nxt.dir_s  = s_r.dir_m;
    s_nxt.wr_pulse = 1'b0;
    sck_rise = s_r.sck_s & ~s_r.sck_d;
    sck_fall = ~s_r.sck_s & s_r.sck_d;
    cs_end   = s_r.csn_s & ~s_r.csn_d;
    cs_start = ~s_r.csn_s & s_r.csn_d;
    // read-back word, loaded at select
    unique case (s_r.readback_select)
      sdcw_pkg::RDS_MICROSTEP_POSITION: mhi = s_r.microstep_position;
      sdcw_pkg::RDS_STALL: mhi = STALL_LOAD;
      default:             mhi = {STALL_LOAD[9:5], CURRENT_SCALE};
    endcase
    if (cs_start) begin
      s_nxt.shout = {mhi, 2'h0, STATUS_FLAGS};
      s_nxt.bits  = '0;
      s_nxt.sdo   = mhi[9];
    end else if (!s_r.csn_s && sck_rise) begin
      s_nxt.shin = {s_r.shin[18:0], s_r.sdi_s};
      if (s_r.bits != 5'h1f) begin
        s_nxt.bits = s_r.bits + 5'h01;
      end
    end else if (!s_r.csn_s && sck_fall) begin
      s_nxt.shout = {s_r.shout[18:0], 1'b0};
      s_nxt.sdo   = s_r.shout[18];
    end
    // commit at deselect: only whole 20-bit words
    if (cs_end && s_r.bits == 5'(sdcw_pkg::WORD_W)) begin
      w = s_r.shin;
      s_nxt.wr_pulse = 1'b1;
      if (!w[sdcw_pkg::SEL_BIT]) begin
        if (s_r.sd_off) begin
          s_nxt.ph_u.pol = w[sdcw_pkg::PHU_POL_BIT];
          s_nxt.ph_u.mag = w[sdcw_pkg::PHU_MAG_HI:sdcw_pkg::PHU_MAG_LO];
          s_nxt.ph_v.pol = w[sdcw_pkg::PHV_POL_BIT];
          s_nxt.ph_v.mag = w[sdcw_pkg::PHV_MAG_HI:0];
        end else begin
          s_nxt.step_interpolation_enable = w[sdcw_pkg::STEP_INTERPOLATION_ENABLE_BIT];
          s_nxt.dual_edge_step_enable  = w[sdcw_pkg::DUAL_EDGE_STEP_ENABLE_BIT];
          if (w[3:0] <= sdcw_pkg::MICROSTEP_RESOLUTION_MAX) begin
            s_nxt.microstep_resolution = w[3:0];
          end
        end
      end else if (w[19:17] == sdcw_pkg::CFG_SEL) begin
        s_nxt.sd_off = w[sdcw_pkg::CFG_SD_BIT];
        s_nxt.readback_select  = w[sdcw_pkg::CFG_RS_HI:sdcw_pkg::CFG_RS_LO];
      end
    end
    // phase w = -(u + v), signed
    su = s_r.ph_u.pol ? -$signed({2'b00, s_r.ph_u.mag})
                      : $signed({2'b00, s_r.ph_u.mag});
    sv = s_r.ph_v.pol ? -$signed({2'b00, s_r.ph_v.mag})
                      : $signed({2'b00, s_r.ph_v.mag});
    sw = -(su + sv);
    s_nxt.ph_w_pol = sw[9];
    s_nxt.ph_w_mag = sw[9] ? 9'(-sw) : sw[8:0];
    // step handling: dual edge and interpolation
    step_ev = s_r.dual_edge_step_enable ? (s_r.step_s ^ s_r.step_d)
                        : (s_r.step_s & ~s_r.step_d);
    stepw = 10'(10'h001 << s_r.microstep_resolution);
    if (!s_r.sd_off) begin
      if (step_ev) begin
        if (s_r.step_interpolation_enable && s_r.microstep_resolution == sdcw_pkg::MICROSTEP_RESOLUTION_INT) begin
          s_nxt.sub_left = sdcw_pkg::INT_MULT;
          s_nxt.sub_dir  = s_r.dir_s;
          s_nxt.microstep_position = s_r.dir_s ? s_r.microstep_position - 10'h001
                                  : s_r.microstep_position + 10'h001;
        end else begin
          // no realignment on resolution change
          s_nxt.microstep_position = s_r.dir_s ? s_r.microstep_position - stepw
                                  : s_r.microstep_position + stepw;
        end
      end else if (s_r.sub_left != 4'h0) begin
        s_nxt.sub_left = s_r.sub_left - 4'h1;
        s_nxt.microstep_position = s_r.sub_dir ? s_r.microstep_position - 10'h001
                                  : s_r.microstep_position + 10'h001;
      end
    end
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r          <= '0;
      s_r.sck_m    <= 1'b0;
      s_r.csn_m    <= 1'b1;
      s_r.csn_s    <= 1'b1;
      s_r.csn_d    <= 1'b1;
      s_r.microstep_position    <= sdcw_pkg::MICROSTEP_POSITION_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign SDO             = s_r.sdo;
  assign STEPDIR_DISABLE = s_r.sd_off;
  assign PHASE_U_POL     = s_r.ph_u.pol;
  assign PHASE_U_MAG     = s_r.ph_u.mag;
  assign PHASE_V_POL     = s_r.ph_v.pol;
  assign PHASE_V_MAG     = s_r.ph_v.mag;
  assign PHASE_W_POL     = s_r.ph_w_pol;
  assign PHASE_W_MAG     = s_r.ph_w_mag;
  assign INTERP_EN       = s_r.step_interpolation_enable;
  assign DUAL_EDGE_EN    = s_r.dual_edge_step_enable;
  assign MICROSTEP_RES   = s_r.microstep_resolution;
  assign MICROSTEP_POS   = s_r.microstep_position;
  assign WORD_STROBE     = s_r.wr_pulse;

  // ****************************************************
  // assertions
  // ****************************************************
  a_phase_w_sum: assert property (@(posedge MCLK) disable iff (!RST_N)
    ##1 ($past(s_r.ph_u.mag) == s_r.ph_u.mag &&
         $past(s_r.ph_v.mag) == s_r.ph_v.mag &&
         $past(s_r.ph_u.pol) == s_r.ph_u.pol &&
         $past(s_r.ph_v.pol) == s_r.ph_v.pol) |->
    ((s_r.ph_u.pol ? -int'(s_r.ph_u.mag) : int'(s_r.ph_u.mag)) +
     (s_r.ph_v.pol ? -int'(s_r.ph_v.mag) : int'(s_r.ph_v.mag)) +
     (s_r.ph_w_pol ? -int'(s_r.ph_w_mag) : int'(s_r.ph_w_mag)) == 0))
    else $error("phase w not negated sum");
  a_rb_microstep_position: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s_r.csn_d && !s_r.csn_s && s_r.readback_select == sdcw_pkg::RDS_MICROSTEP_POSITION)
    |=> s_r.shout[19:10] == $past(s_r.microstep_position))
    else $error("read-back high bits not position");
  a_rb_flags: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s_r.csn_d && !s_r.csn_s) |=> s_r.shout[7:0] == $past(STATUS_FLAGS))
    else $error("read-back flags wrong");
  a_commit_only_end: assert property (@(posedge MCLK)
    disable iff (!RST_N)
    s_r.wr_pulse |-> $past(s_r.csn_s) && !$past(s_r.csn_d))
    else $error("word committed without deselect");
  a_mode_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!s_r.wr_pulse && !$past(s_r.wr_pulse)) |-> $stable(s_r.sd_off))
    else $error("mode changed without word");
  a_direct_fields: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s_r.csn_s && !s_r.csn_d && s_r.bits == 5'h14 && !s_r.shin[19]
     && s_r.sd_off) |=> s_r.ph_u.mag == $past(s_r.shin[16:9]) &&
     s_r.ph_v.pol == $past(s_r.shin[8]))
    else $error("direct fields misdecoded");
  a_cfg_route: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s_r.csn_s && !s_r.csn_d && s_r.shin[19]) |=>
    $stable(s_r.ph_u) && $stable(s_r.microstep_resolution))
    else $error("config word touched driver control");
  a_dual_edge_step_enable_step: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!s_r.sd_off && s_r.dual_edge_step_enable && (s_r.step_s ^ s_r.step_d) &&
     !s_r.step_interpolation_enable) |=> !$stable(s_r.microstep_position))
    else $error("dual edge step lost");
  a_res_range: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_r.microstep_resolution <= sdcw_pkg::MICROSTEP_RESOLUTION_MAX)
    else $error("resolution code out of range");
  c_word_commit: cover property (@(posedge MCLK) s_r.wr_pulse);
  c_direct_mode: cover property (@(posedge MCLK) s_r.sd_off && s_r.wr_pulse);
  c_interp: cover property (@(posedge MCLK) s_r.sub_left == 4'h1);
  c_scale_rd: cover property (@(posedge MCLK)
    s_r.readback_select == sdcw_pkg::RDS_SCALE && !s_r.csn_s);
endmodule : sdcw_core
`default_nettype wire

/* File: verification/sdcw_host.sv */
// Purpose: serial master model that writes words and collects read-back
// Assumes: mode 0, serial clock of 400 ns built from MCLK edges
// Notes:   serial clock idles low between frames; data line toggles then
`timescale 1ns/1ps
`default_nettype none
module sdcw_host (
  // clock
  input  wire logic MCLK,
  // serial pins
  output logic      SCK,
  output logic      CS_N,
  output logic      SDI,
  input  wire logic SDO
);
  initial begin
    SCK  = 1'b0;
    CS_N = 1'b1;
    SDI  = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #2;
  endtask : cyc

  // sends the top n bits of w, msb first, and returns what came back
  task automatic xfer(input logic [19:0] w, input int n,
                      output logic [19:0] rd);
    rd   = 20'h00000;
    CS_N = 1'b0;
    cyc(8);
    for (int i = 0; i < n; i++) begin
      SDI = w[19-i];
      cyc(4);
      rd[19-i] = SDO;
      SCK      = 1'b1;
      cyc(4);
      SCK = 1'b0;
    end
    CS_N = 1'b1;
    SDI  = ~SDI;
  endtask : xfer
endmodule : sdcw_host
`default_nettype wire

/* File: verification/stepper_drive_ctrl_word_decode_test.sv */
// Purpose: self-checking bench for the driver-control word decoder
// Assumes: host model drives the serial pins; status inputs are static
// Notes:   direction pin stays low, so every step counts upward
`timescale 1ns/1ps
`default_nettype none
module stepper_drive_ctrl_word_decode_test;
  logic MCLK, RST_N, SCK, CS_N, SDI, SDO, STEP, DIR;
  logic [9:0] STALL_LOAD, MICROSTEP_POS;
  logic [4:0] CURRENT_SCALE;
  logic [7:0] STATUS_FLAGS, PHASE_U_MAG, PHASE_V_MAG;
  logic STEPDIR_DISABLE, PHASE_U_POL, PHASE_V_POL, PHASE_W_POL;
  logic [8:0] PHASE_W_MAG;
  logic INTERP_EN, DUAL_EDGE_EN, WORD_STROBE;
  logic [3:0] MICROSTEP_RES;
  logic [19:0] rd;
  logic [9:0] p0;
  logic [9:0] sel_exp [3] = '{10'h000, 10'h2a5, 10'h2b3};
  int errors = 0;
  int n_checks = 0;

  sdcw_core i_sdcw_core (.MCLK(MCLK), .RST_N(RST_N), .SCK(SCK),
    .CS_N(CS_N), .SDI(SDI), .SDO(SDO), .STEP(STEP), .DIR(DIR),
    .STALL_LOAD(STALL_LOAD), .CURRENT_SCALE(CURRENT_SCALE),
    .STATUS_FLAGS(STATUS_FLAGS), .STEPDIR_DISABLE(STEPDIR_DISABLE),
    .PHASE_U_POL(PHASE_U_POL), .PHASE_U_MAG(PHASE_U_MAG),
    .PHASE_V_POL(PHASE_V_POL), .PHASE_V_MAG(PHASE_V_MAG),
    .PHASE_W_POL(PHASE_W_POL), .PHASE_W_MAG(PHASE_W_MAG),
    .INTERP_EN(INTERP_EN), .DUAL_EDGE_EN(DUAL_EDGE_EN),
    .MICROSTEP_RES(MICROSTEP_RES), .MICROSTEP_POS(MICROSTEP_POS),
    .WORD_STROBE(WORD_STROBE));
  sdcw_host i_sdcw_host (.MCLK(MCLK), .SCK(SCK), .CS_N(CS_N), .SDI(SDI),
    .SDO(SDO));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #2;
  endtask : cyc

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [19:0] w, input int n, input logic s);
    logic got;
    got = 1'b0;
    i_sdcw_host.xfer(w, n, rd);
    repeat (12) begin
      cyc(1);
      if (WORD_STROBE === 1'b1) got = 1'b1;
    end
    if (s !== 1'bx) chk(got, s);
  endtask : wr

  task automatic cfg(input logic sd, input logic [1:0] sel);
    wr({3'h7, 9'h000, sd, 1'b0, sel, 4'h0}, 20, 1'b1);
  endtask : cfg

  task automatic stepchk(input logic [9:0] w);
    logic [9:0] p, d;
    p = MICROSTEP_POS;
    STEP = 1'b1;
    cyc(12);
    STEP = 1'b0;
    cyc(24);
    d = MICROSTEP_POS - p;
    chk(d, w);
  endtask : stepchk

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // clock, watchdog and tests
  // ****************************************************************
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end

  initial begin
    repeat (30000) @(posedge MCLK);
    errors++;
    report_and_stop();
  end

  initial begin
    RST_N = 1'b0;
    STEP = 1'b0;
    DIR = 1'b0;
    STALL_LOAD = 10'h2a5;
    CURRENT_SCALE = 5'h13;
    STATUS_FLAGS = 8'h5a;
    repeat (10) @(posedge MCLK);
    #2 RST_N = 1'b1;
    cyc(3);
    chk(STEPDIR_DISABLE, 1'b0);
    chk(MICROSTEP_POS, 10'h000);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      cfg(1'b0, k[1:0]);
      cfg(1'b0, k[1:0]);
      chk(rd, {sel_exp[k], 2'h0, 8'h5a});
    end
    $display("test readback done");
    for (int c = 0; c < 9; c++) begin
      p0 = MICROSTEP_POS;
      wr({2'h0, 8'hff, 2'h0, 4'hf, c[3:0]}, 20, 1'b1);
      chk(MICROSTEP_RES, c[3:0]);
      chk(MICROSTEP_POS, p0);
      chk({INTERP_EN, DUAL_EDGE_EN}, 2'h0);
      stepchk((c == 8) ? 10'h100 : (10'h001 << c));
    end
    wr({10'h000, 2'h1, 8'h00}, 20, 1'b1);
    chk(DUAL_EDGE_EN, 1'b1);
    stepchk(10'h002);
    wr({10'h000, 2'h2, 8'h04}, 20, 1'b1);
    chk(INTERP_EN, 1'b1);
    stepchk(10'h010);
    $display("test step mode done");
    cfg(1'b1, 2'h0);
    chk(STEPDIR_DISABLE, 1'b1);
    wr({3'h0, 8'h64, 1'b0, 8'h30}, 20, 1'b1);
    chk({PHASE_U_POL, PHASE_U_MAG, PHASE_V_POL, PHASE_V_MAG},
        {1'b0, 8'h64, 1'b0, 8'h30});
    chk({PHASE_W_POL, PHASE_W_MAG}, {1'b1, 9'h094});
    wr({3'h0, 8'hc8, 1'b1, 8'h30}, 20, 1'b1);
    chk({PHASE_U_POL, PHASE_U_MAG, PHASE_V_POL, PHASE_V_MAG},
        {1'b0, 8'hc8, 1'b1, 8'h30});
    chk({PHASE_W_POL, PHASE_W_MAG}, {1'b1, 9'h098});
    wr(20'h00000, 19, 1'b0);
    chk(PHASE_U_MAG, 8'hc8);
    wr(20'h80000, 20, 1'b1);
    chk({STEPDIR_DISABLE, PHASE_U_MAG}, {1'b1, 8'hc8});
    $display("test direct mode done");
    report_and_stop();
  end
endmodule : stepper_drive_ctrl_word_decode_test
`default_nettype wire
